// ===== logic/csat_ctrl.sv
// Purpose: control, status and automatic buffer transfer of a 3-wire serial unit
// Assumes: clock_i is the oscillator clock; memory port reads answer two cycles later
// Notes:   interface enable low clears state on the next edge, not truly asynchronously
//
// Contract
// - status bits 0 and 1 are read-only
// - strobe enable works only as clock master
// - strobe forces two clocks between bytes
// - error detection compares busy with level bit
// - error enable gates detection, busy-wait independent
// - busy active during data bits sets error
// - error clears at reset, disable, start
// - active flag high from start to end
// - active clears at reset, disable, end, stop
// - buffer writes accepted during transfer
// - trigger bit0 starts, bit1 stops, zeros ignored
// - start or stop waits for byte end
// - trigger bits self-clear after transfer interrupt
// - stop keeps address count, no resume
// - divisor code selects base/6,/8,/16,/32
// - end address is 5-bit buffer index
// - single transfer runs base through end address
// - repeat transfer wraps to start until stopped
// - base clock is oscillator or half of it
// - disable drives output low, clock high, resets
// - busy wait holds master transfer until busy inactive
// - master inserts 0..63 clock interval per byte
`timescale 1ns/1ps
module csat_ctrl (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // processor memory port
    input  wire logic [15:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    // serial pins
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        si_i,
    output logic             so_o,
    output logic             stb_o,
    input  wire logic        busy_i,
    // transfer event
    output logic             irq_o
);
    csat_ram_if ram_bus ();

    csat_buffer_ram u_ram (
        .clock_i (clock_i),
        .ram     (ram_bus.ram)
    );

    // registers
    logic [7:0]  serial_mode_control;
    logic [7:0]  status_cfg;
    logic        bit_error_flag;
    logic        transfer_active_flag;
    logic        auto_start_trigger;
    logic        auto_stop_trigger;
    logic [1:0]  serial_clock_divisor;
    logic [4:0]  auto_transfer_end_address;
    logic [5:0]  byte_interval_setting;
    logic [7:0]  serial_shift_register;
    logic [4:0]  buffer_address_count;

    // engine state
    csat_pkg::csat_state_e state;
    logic [2:0]  bit_cnt;
    logic [5:0]  wait_cnt;
    logic [5:0]  div_cnt;
    logic        half_toggle;
    logic        rd_q;
    logic [2:0]  rd_sel_q;
    logic [7:0]  rd_hold;

    // synchronisers: stage one is read only by stage two
    logic [1:0]  si_sync;
    logic [1:0]  busy_sync;
    logic [2:0]  sck_sync;

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b, input logic lsb);
        shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction : shift_in

    function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
        out_bit = lsb ? sr[0] : sr[7];
    endfunction : out_bit

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // mode decode
    wire         en_w      = serial_mode_control[csat_pkg::MODE_ENABLE];
    wire         auto_w    = serial_mode_control[csat_pkg::MODE_AUTO];
    wire         repeat_w  = serial_mode_control[csat_pkg::MODE_REPEAT];
    wire         master_w  = serial_mode_control[csat_pkg::MODE_MASTER];
    wire         tx_w      = serial_mode_control[csat_pkg::MODE_TX];
    wire         rx_w      = serial_mode_control[csat_pkg::MODE_RX];
    wire         lsb_w     = serial_mode_control[csat_pkg::MODE_LSB];
    wire         strobe_w  = status_cfg[csat_pkg::ST_STROBE] & master_w;
    wire         busy_en_w = status_cfg[csat_pkg::ST_BUSY_EN];
    wire         busy_on_w = (busy_sync[1] == status_cfg[csat_pkg::ST_BUSY_LVL]);

    // bus decode
    wire         ram_hit_w   = ((addr_i & csat_pkg::ADDR_RAM_MASK) == csat_pkg::ADDR_RAM_BASE);
    wire         wr_mode_w   = wr_i & hit(addr_i, csat_pkg::ADDR_MODE);
    wire         wr_stat_w   = wr_i & hit(addr_i, csat_pkg::ADDR_STATUS);
    wire         wr_trig_w   = wr_i & hit(addr_i, csat_pkg::ADDR_TRIGGER);
    wire         wr_div_w    = wr_i & hit(addr_i, csat_pkg::ADDR_DIVISOR);
    wire         wr_end_w    = wr_i & hit(addr_i, csat_pkg::ADDR_END);
    wire         wr_int_w    = wr_i & hit(addr_i, csat_pkg::ADDR_INTERVAL);
    wire         wr_shift_w  = wr_i & hit(addr_i, csat_pkg::ADDR_SHIFT);
    wire         start_req_w = wr_trig_w & auto_w & wdata_i[csat_pkg::TRG_START];
    wire         stop_req_w  = wr_trig_w & auto_w & wdata_i[csat_pkg::TRG_STOP];
    wire         single_go_w = wr_shift_w & en_w & ~auto_w & ~transfer_active_flag;

    // serial clock generation
    wire         base_en_w = ~status_cfg[csat_pkg::ST_BASE_HALF] | half_toggle;
    wire [5:0]   div_n_w   = (serial_clock_divisor == 2'h0) ? csat_pkg::DIV_CODE0 :
                             (serial_clock_divisor == 2'h1) ? csat_pkg::DIV_CODE1 :
                             (serial_clock_divisor == 2'h2) ? csat_pkg::DIV_CODE2 :
                                                              csat_pkg::DIV_CODE3;
    wire         rise_m_w  = base_en_w & (div_cnt == ((div_n_w >> 1) - 6'd1));
    wire         fall_m_w  = base_en_w & (div_cnt == (div_n_w - 6'd1));
    wire         rise_s_w  = sck_sync[1] & ~sck_sync[2];
    wire         fall_s_w  = ~sck_sync[1] & sck_sync[2];
    wire         rise_w    = master_w ? rise_m_w : rise_s_w;
    wire         fall_w    = master_w ? fall_m_w : fall_s_w;

    // forced gap takes priority over a shorter programmed interval
    wire [5:0]   gap_w     = strobe_w ? csat_pkg::GAP_STROBE :
                             busy_en_w ? csat_pkg::GAP_BUSY : 6'd0;
    wire [5:0]   wait_n_w  = (byte_interval_setting > gap_w) ? byte_interval_setting : gap_w;
    wire         hold_w    = busy_en_w & busy_on_w;
    wire         at_end_w  = (buffer_address_count == auto_transfer_end_address);

    // processor read selection
    wire [2:0]   rd_sel_w  = ram_hit_w ? 3'd1 : 3'd0;
    wire [7:0]   reg_rd_w  =
        hit(addr_i, csat_pkg::ADDR_MODE)     ? serial_mode_control :
        hit(addr_i, csat_pkg::ADDR_STATUS)   ? {1'b0, status_cfg[6:2], bit_error_flag, transfer_active_flag} :
        hit(addr_i, csat_pkg::ADDR_TRIGGER)  ? {6'h00, auto_stop_trigger, auto_start_trigger} :
        hit(addr_i, csat_pkg::ADDR_DIVISOR)  ? {6'h00, serial_clock_divisor} :
        hit(addr_i, csat_pkg::ADDR_END)      ? {3'h0, auto_transfer_end_address} :
        hit(addr_i, csat_pkg::ADDR_INTERVAL) ? {2'h0, byte_interval_setting} :
        hit(addr_i, csat_pkg::ADDR_SHIFT)    ? serial_shift_register :
        hit(addr_i, csat_pkg::ADDR_COUNT)    ? {3'h0, buffer_address_count} : 8'h00;

    // buffer ports; the buffer is closed while the unit is disabled
    assign ram_bus.cpu_we    = wr_i & ram_hit_w & en_w;
    assign ram_bus.cpu_addr  = addr_i[4:0];
    assign ram_bus.cpu_wdata = wdata_i;
    assign ram_bus.eng_we    = (state == csat_pkg::CSAT_DONE) & auto_w & rx_w;
    assign ram_bus.eng_addr  = buffer_address_count;
    assign ram_bus.eng_wdata = serial_shift_register;

    always_ff @(posedge clock_i) begin
        si_sync   <= {si_sync[0], si_i};
        busy_sync <= {busy_sync[0], busy_i};
        sck_sync  <= {sck_sync[1:0], sck_i};
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rd_q     <= 1'b0;
            rd_sel_q <= 3'd0;
            rd_hold  <= 8'h00;
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rd_q     <= rd_i;
            rd_sel_q <= rd_sel_w;
            rd_hold  <= reg_rd_w;
            rvalid_o <= rd_q;
            if (rd_q) begin
                rdata_o <= (rd_sel_q == 3'd1) ? (en_w ? ram_bus.cpu_rdata : 8'h00) : rd_hold;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            serial_mode_control       <= csat_pkg::RST_MODE;
            status_cfg                <= csat_pkg::RST_STATUS;
            serial_clock_divisor      <= csat_pkg::RST_DIVISOR;
            auto_transfer_end_address <= csat_pkg::RST_END;
            byte_interval_setting     <= csat_pkg::RST_INTERVAL;
        end else begin
            if (wr_mode_w) begin
                serial_mode_control <= wdata_i & csat_pkg::MODE_WMASK;
            end
            if (wr_stat_w) begin
                status_cfg <= wdata_i & csat_pkg::ST_WMASK;
            end
            if (wr_div_w) begin
                serial_clock_divisor <= wdata_i[1:0];
            end
            if (wr_end_w) begin
                auto_transfer_end_address <= wdata_i[4:0];
            end
            if (wr_int_w) begin
                byte_interval_setting <= wdata_i[5:0];
            end
        end
    end

    // bit error flag: a detection wins over everything but reset and disable
    always_ff @(posedge clock_i) begin
        if (reset_i || !en_w) begin
            bit_error_flag <= 1'b0;
        end else if ((state == csat_pkg::CSAT_SHIFT) && status_cfg[csat_pkg::ST_ERR_EN] && busy_on_w) begin
            bit_error_flag <= 1'b1;
        end else if (single_go_w || (state == csat_pkg::CSAT_IDLE && auto_w && auto_start_trigger)) begin
            bit_error_flag <= 1'b0;
        end
    end

    // trigger bits hold a request until the byte's transfer event
    always_ff @(posedge clock_i) begin
        if (reset_i || !en_w) begin
            auto_start_trigger <= 1'b0;
            auto_stop_trigger  <= 1'b0;
        end else begin
            // a request written in the event cycle survives the self-clear
            if (start_req_w) begin
                auto_start_trigger <= 1'b1;
            end else if (state == csat_pkg::CSAT_DONE) begin
                auto_start_trigger <= 1'b0;
            end
            if (stop_req_w) begin
                auto_stop_trigger <= 1'b1;
            end else if (state == csat_pkg::CSAT_DONE) begin
                auto_stop_trigger <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            half_toggle <= 1'b0;
        end else begin
            half_toggle <= ~half_toggle;
        end
    end

    // divider is held in idle and prime so each byte starts on a clean period
    always_ff @(posedge clock_i) begin
        if (reset_i || state == csat_pkg::CSAT_IDLE || state == csat_pkg::CSAT_PRIME) begin
            div_cnt <= 6'd0;
        end else if (fall_m_w) begin
            div_cnt <= 6'd0;
        end else if (base_en_w) begin
            div_cnt <= div_cnt + 6'd1;
        end
    end

    // transfer engine
    always_ff @(posedge clock_i) begin
        if (reset_i || !en_w) begin
            state                 <= csat_pkg::CSAT_IDLE;
            transfer_active_flag  <= 1'b0;
            serial_shift_register <= 8'h00;
            buffer_address_count  <= 5'h00;
            bit_cnt               <= 3'd0;
            wait_cnt              <= 6'd0;
            sck_o                 <= 1'b1;
            sck_oe_o              <= 1'b0;
            so_o                  <= 1'b0;
            stb_o                 <= 1'b0;
            irq_o                 <= 1'b0;
        end else begin
            irq_o    <= 1'b0;
            sck_oe_o <= master_w;
            case (state)
                csat_pkg::CSAT_IDLE: begin
                    sck_o <= 1'b1;
                    stb_o <= 1'b0;
                    if (single_go_w) begin
                        serial_shift_register <= wdata_i;
                        transfer_active_flag  <= 1'b1;
                        state                 <= csat_pkg::CSAT_PRIME;
                    end else if (auto_w && auto_start_trigger && !transfer_active_flag) begin
                        buffer_address_count <= 5'h00;
                        transfer_active_flag <= 1'b1;
                        state                <= csat_pkg::CSAT_FETCH;
                    end
                end
                csat_pkg::CSAT_FETCH: begin
                    state <= csat_pkg::CSAT_PRIME;
                end
                csat_pkg::CSAT_PRIME: begin
                    if (auto_w) begin
                        serial_shift_register <= ram_bus.eng_rdata;
                        so_o <= tx_w & out_bit(ram_bus.eng_rdata, lsb_w);
                    end else begin
                        so_o <= tx_w & out_bit(serial_shift_register, lsb_w);
                    end
                    bit_cnt <= 3'd0;
                    if (master_w) begin
                        sck_o <= 1'b0;
                    end
                    state <= csat_pkg::CSAT_SHIFT;
                end
                csat_pkg::CSAT_SHIFT: begin
                    if (rise_w) begin
                        sck_o <= 1'b1;
                        serial_shift_register <= shift_in(serial_shift_register, si_sync[1], lsb_w);
                        bit_cnt <= bit_cnt + 3'd1;    // wraps to zero on the eighth rise
                        if (bit_cnt == csat_pkg::BITS_LAST && !master_w) begin
                            state <= csat_pkg::CSAT_DONE;
                        end
                    end else if (fall_w) begin
                        if (master_w && bit_cnt == 3'd0) begin
                            wait_cnt <= 6'd0;
                            stb_o    <= strobe_w;
                            state    <= (wait_n_w == 6'd0 && !hold_w) ? csat_pkg::CSAT_DONE
                                                                      : csat_pkg::CSAT_GAP;
                        end else begin
                            sck_o <= ~master_w;
                            so_o  <= tx_w & out_bit(serial_shift_register, lsb_w);
                        end
                    end
                end
                csat_pkg::CSAT_GAP: begin
                    if (fall_m_w && !hold_w) begin
                        stb_o    <= 1'b0;
                        wait_cnt <= wait_cnt + 6'd1;
                        if (wait_cnt + 6'd1 >= wait_n_w) begin
                            state <= csat_pkg::CSAT_DONE;
                        end
                    end
                end
                csat_pkg::CSAT_DONE: begin
                    irq_o <= 1'b1;
                    stb_o <= 1'b0;
                    if (!auto_w) begin
                        transfer_active_flag <= 1'b0;
                        state                <= csat_pkg::CSAT_IDLE;
                    end else if (auto_stop_trigger) begin
                        buffer_address_count <= buffer_address_count + 5'h01;
                        transfer_active_flag <= 1'b0;
                        state                <= csat_pkg::CSAT_IDLE;
                    end else if (at_end_w && !repeat_w) begin
                        buffer_address_count <= buffer_address_count + 5'h01;
                        transfer_active_flag <= 1'b0;
                        state                <= csat_pkg::CSAT_IDLE;
                    end else if (at_end_w) begin
                        buffer_address_count <= 5'h00;
                        state                <= csat_pkg::CSAT_FETCH;
                    end else begin
                        buffer_address_count <= buffer_address_count + 5'h01;
                        state                <= csat_pkg::CSAT_FETCH;
                    end
                end
                default: begin
                    state <= csat_pkg::CSAT_IDLE;
                end
            endcase
        end
    end
endmodule : csat_ctrl

// ===== logic/csat_pkg.sv
// Purpose: shared constants of the clocked serial auto transfer controller
// Assumes: byte-wide processor memory port, 16-bit addresses
// Notes:   one definition per number; every user writes csat_pkg::name
package csat_pkg;

    // register addresses on the processor memory port
    localparam logic [15:0] ADDR_MODE      = 16'hff90;
    localparam logic [15:0] ADDR_STATUS    = 16'hff91;
    localparam logic [15:0] ADDR_TRIGGER   = 16'hff92;
    localparam logic [15:0] ADDR_DIVISOR   = 16'hff93;
    localparam logic [15:0] ADDR_END       = 16'hff94;
    localparam logic [15:0] ADDR_INTERVAL  = 16'hff95;
    localparam logic [15:0] ADDR_SHIFT     = 16'hff96;
    localparam logic [15:0] ADDR_COUNT     = 16'hff97;
    localparam logic [15:0] ADDR_RAM_BASE  = 16'hfa00;
    localparam logic [15:0] ADDR_RAM_MASK  = 16'hffe0;

    // buffer geometry
    localparam int          RAM_AW         = 5;
    localparam int          RAM_DEPTH      = 32;

    // mode register fields
    localparam int          MODE_ENABLE    = 7;
    localparam int          MODE_AUTO      = 6;
    localparam int          MODE_REPEAT    = 5;
    localparam int          MODE_MASTER    = 4;
    localparam int          MODE_TX        = 3;
    localparam int          MODE_RX        = 2;
    localparam int          MODE_LSB       = 1;
    localparam logic [7:0]  MODE_WMASK     = 8'hfe;

    // status register fields
    localparam int          ST_BASE_HALF   = 6;
    localparam int          ST_STROBE      = 5;
    localparam int          ST_BUSY_EN     = 4;
    localparam int          ST_BUSY_LVL    = 3;
    localparam int          ST_ERR_EN      = 2;
    localparam int          ST_ERR_FLAG    = 1;
    localparam int          ST_ACTIVE      = 0;
    localparam logic [7:0]  ST_WMASK       = 8'h7c;

    // trigger register fields
    localparam int          TRG_START      = 0;
    localparam int          TRG_STOP       = 1;

    // reset values
    localparam logic [7:0]  RST_MODE       = 8'h00;
    localparam logic [7:0]  RST_STATUS     = 8'h00;
    localparam logic [1:0]  RST_DIVISOR    = 2'h3;
    localparam logic [4:0]  RST_END        = 5'h00;
    localparam logic [5:0]  RST_INTERVAL   = 6'h00;

    // base clock ticks per serial clock for each divisor code
    localparam logic [5:0]  DIV_CODE0      = 6'd6;
    localparam logic [5:0]  DIV_CODE1      = 6'd8;
    localparam logic [5:0]  DIV_CODE2      = 6'd16;
    localparam logic [5:0]  DIV_CODE3      = 6'd32;

    // serial clocks between bytes forced by strobe and busy options; index of the last data bit
    localparam logic [5:0]  GAP_STROBE     = 6'd2;
    localparam logic [5:0]  GAP_BUSY       = 6'd1;
    localparam logic [2:0]  BITS_LAST      = 3'd7;

    typedef enum logic [2:0] {
        CSAT_IDLE,
        CSAT_FETCH,
        CSAT_PRIME,
        CSAT_SHIFT,
        CSAT_GAP,
        CSAT_DONE
    } csat_state_e;

endpackage : csat_pkg

// ===== logic/csat_ram_if.sv
// Purpose: carrier between controller and its transfer buffer
// Assumes: both ports on clock_i
// Notes:   processor port and engine port, each with registered read data
`timescale 1ns/1ps
interface csat_ram_if;
    logic       cpu_we;
    logic [4:0] cpu_addr;
    logic [7:0] cpu_wdata;
    logic [7:0] cpu_rdata;
    logic       eng_we;
    logic [4:0] eng_addr;
    logic [7:0] eng_wdata;
    logic [7:0] eng_rdata;

    modport ram  (input cpu_we, cpu_addr, cpu_wdata, eng_we, eng_addr, eng_wdata,
                  output cpu_rdata, eng_rdata);
    modport user (output cpu_we, cpu_addr, cpu_wdata, eng_we, eng_addr, eng_wdata,
                  input cpu_rdata, eng_rdata);
endinterface : csat_ram_if

// ===== logic/csat_buffer_ram.sv
// Purpose: 32-byte transfer buffer with two ports
// Assumes: same-address writes in one cycle are rare
// Notes:   processor write wins over engine write on an address clash
`timescale 1ns/1ps
module csat_buffer_ram (
    // clock
    input  wire logic  clock_i,
    // ports
    csat_ram_if.ram    ram
);
    logic [7:0] mem [csat_pkg::RAM_DEPTH];

    always_ff @(posedge clock_i) begin
        if (ram.eng_we) begin
            mem[ram.eng_addr] <= ram.eng_wdata;
        end
        if (ram.cpu_we) begin
            mem[ram.cpu_addr] <= ram.cpu_wdata;
        end
        ram.cpu_rdata <= mem[ram.cpu_addr];
        ram.eng_rdata <= mem[ram.eng_addr];
    end
endmodule : csat_buffer_ram

// ===== tb/csat_ctrl_props.sv
// Purpose: port-level checks of csat_ctrl
// Assumes: one clock domain, mode inferred from bus writes
// Notes:   pin checks after a disable allow three edges of settling
`timescale 1ns/1ps
module csat_ctrl_props (
    input wire logic        clock_i, reset_i, wr_i, rd_i, rvalid_o, sck_o, sck_oe_o, so_o, stb_o, irq_o,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    wire mw = wr_i && (addr_i == csat_pkg::ADDR_MODE);
    chk_read_answer: assert property (rd_i |-> ##2 rvalid_o) else $error("read answer late");
    chk_answer_cause: assert property (rvalid_o |-> $past(rd_i, 2)) else $error("stray read answer");
    chk_irq_pulse: assert property (irq_o |=> !irq_o) else $error("event wider than one cycle");
    chk_strobe_master: assert property (stb_o |-> sck_oe_o) else $error("strobe outside master");
    chk_strobe_width: assert property ($rose(stb_o) |-> stb_o[*6]) else $error("strobe too short");
    chk_disable_pins: assert property (mw && !wdata_i[7] |-> ##3 (!so_o && sck_o)) else $error("idle pins");
    chk_oe_cause: assert property ($changed(sck_oe_o) |-> $past(mw) || $past(mw, 2) || $past(mw, 3))
        else $error("clock drive changed without mode write");
    chk_reset_pins: assert property (disable iff (1'b0) reset_i |=> sck_o && !sck_oe_o && !irq_o)
        else $error("pins wrong in reset");
endmodule : csat_ctrl_props
bind csat_ctrl csat_ctrl_props props_u (.clock_i(clock_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
    .rvalid_o(rvalid_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .so_o(so_o), .stb_o(stb_o), .irq_o(irq_o),
    .addr_i(addr_i), .wdata_i(wdata_i));

// ===== tb/csat_periph.sv
// Purpose: clocked serial peripheral on the far side
// Assumes: master mode, clock idles high
// Notes:   answers with the inverse of the last bit taken in
`timescale 1ns/1ps
module csat_periph (
    input  wire logic sck_i,
    input  wire logic sdo_i,
    input  wire logic busy_req_i,
    output logic      sdi_o,
    output logic      busy_o
);
    logic [7:0] rx = 8'h00;
    always @(posedge sck_i) rx <= {rx[6:0], sdo_i};
    assign sdi_o  = ~rx[0];
    assign busy_o = busy_req_i;
endmodule : csat_periph

// ===== tb/csat_ctrl_bench.sv
// Purpose: register-level tests of csat_ctrl
// Assumes: bench drives on the falling edge
// Notes:   every wait is bounded
`timescale 1ns/1ps
module csat_ctrl_bench;
    logic        clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, bz = 0;
    logic [15:0] addr_i = '0;
    logic [7:0]  wdata_i = '0, st;
    logic [5:0]  dv [5] = '{csat_pkg::DIV_CODE0, csat_pkg::DIV_CODE1, csat_pkg::DIV_CODE2,
                            csat_pkg::DIV_CODE3, csat_pkg::DIV_CODE0 << 1};
    wire  [7:0]  rdata_o;
    wire         rvalid_o, sck_o, sck_oe_o, so_o, stb_o, irq_o, si_i, busy_i;
    int          n_mismatch = 0, checks = 0, i, n;
    always #2 clock_i = ~clock_i;
    csat_ctrl dut_u (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sck_i(sck_o), .sck_o(sck_o),
        .sck_oe_o(sck_oe_o), .si_i(si_i), .so_o(so_o), .stb_o(stb_o), .busy_i(busy_i), .irq_o(irq_o));
    csat_periph far_u (.sck_i(sck_o), .sdo_i(so_o), .busy_req_i(bz), .sdi_o(si_i), .busy_o(busy_i));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_i) {addr_i, wdata_i, wr_i} = {a, d, 1'b1};
        @(negedge clock_i) wr_i = 0;
    endtask : wr
    task automatic chk(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(negedge clock_i) {addr_i, rd_i} = {a, 1'b1};
        @(negedge clock_i) rd_i = 0;
        for (i = 0; i < 4 && rvalid_o !== 1'b1; i++) @(posedge clock_i) #1;
        if (rvalid_o !== 1'b1) begin
            cmp("read answer", 8'h01, 8'h00);
            report_and_stop;
        end
        cmp(nm, e, rdata_o);
    endtask : chk
    task automatic wirq;
        for (i = 0; i < 1000 && irq_o !== 1'b1; i++) @(posedge clock_i) #1;
        if (irq_o !== 1'b1) begin
            n_mismatch++;
            report_and_stop;
        end
        @(posedge clock_i) #1;
    endtask : wirq
    initial begin
        repeat (10) @(negedge clock_i);
        reset_i = 0;
        chk(csat_pkg::ADDR_DIVISOR, 8'h03, "divisor");
        chk(csat_pkg::ADDR_END, 8'h00, "end address");
        chk(csat_pkg::ADDR_TRIGGER, 8'h00, "trigger");
        chk(16'h1234, 8'h00, "unmapped");
        wr(csat_pkg::ADDR_STATUS, 8'h7f);
        chk(csat_pkg::ADDR_STATUS, 8'h7c, "status");
        $display("test registers done");
        wr(csat_pkg::ADDR_MODE, 8'h9c);
        for (int c = 0; c < 5; c++) begin
            st = (c == 4) ? 8'h40 : 8'h00;
            wr(csat_pkg::ADDR_STATUS, st);
            wr(csat_pkg::ADDR_DIVISOR, (c == 4) ? 8'h00 : 8'(c));
            wr(csat_pkg::ADDR_SHIFT, 8'ha5);
            chk(csat_pkg::ADDR_STATUS, st | 8'h01, "active");
            for (i = 0; i < 300 && sck_o !== 1'b0; i++) @(posedge clock_i) #1;
            for (i = 0; i < 300 && sck_o !== 1'b1; i++) @(posedge clock_i) #1;
            for (n = 0; n < 300 && sck_o !== 1'b0; n++) @(posedge clock_i) #1;
            for (; n < 300 && sck_o !== 1'b1; n++) @(posedge clock_i) #1;
            cmp("serial period", 8'(dv[c]), 8'(n));
            if (n >= 300) report_and_stop;
            wirq();
            cmp("far side byte", 8'ha5, far_u.rx);
            chk(csat_pkg::ADDR_STATUS, st, "idle");
        end
        $display("test divisor done");
        wr(csat_pkg::ADDR_STATUS, 8'h0c);
        bz = 1;
        wr(csat_pkg::ADDR_SHIFT, 8'h3c);
        wirq();
        chk(csat_pkg::ADDR_STATUS, 8'h0e, "error set");
        bz = 0;
        wr(csat_pkg::ADDR_SHIFT, 8'h3c);
        chk(csat_pkg::ADDR_STATUS, 8'h0d, "error cleared");
        wirq();
        $display("test error done");
        wr(csat_pkg::ADDR_STATUS, 8'h20);
        wr(csat_pkg::ADDR_MODE, 8'hdc);
        for (int k = 0; k < 3; k++) wr(csat_pkg::ADDR_RAM_BASE + 16'(k), 8'(k + 1));
        wr(csat_pkg::ADDR_END, 8'h02);
        wr(csat_pkg::ADDR_TRIGGER, 8'h01);
        wr(csat_pkg::ADDR_RAM_BASE + 16'h5, 8'h5a);
        repeat (3) wirq();
        cmp("far side byte", 8'h03, far_u.rx);
        chk(csat_pkg::ADDR_STATUS, 8'h20, "single end");
        chk(csat_pkg::ADDR_COUNT, 8'h03, "count");
        chk(csat_pkg::ADDR_RAM_BASE + 16'h5, 8'h5a, "ram write in transfer");
        wr(csat_pkg::ADDR_MODE, 8'hfc);
        wr(csat_pkg::ADDR_END, 8'h01);
        wr(csat_pkg::ADDR_TRIGGER, 8'h01);
        repeat (3) wirq();
        chk(csat_pkg::ADDR_STATUS, 8'h21, "repeat active");
        wr(csat_pkg::ADDR_TRIGGER, 8'h02);
        wirq();
        chk(csat_pkg::ADDR_STATUS, 8'h20, "stopped");
        chk(csat_pkg::ADDR_TRIGGER, 8'h00, "trigger clear");
        wr(csat_pkg::ADDR_MODE, 8'h00);
        chk(csat_pkg::ADDR_COUNT, 8'h00, "count cleared");
        $display("test auto done");
        report_and_stop();
    end
endmodule : csat_ctrl_bench
